/* hw/sector_protect.sv */
// What this block does
// [RULE1] With write protect asserted, refuse map changes and work on protected sectors.
// [RULE2] Asserting write protect turns protection on within the assert delay.
// [RULE3] Releasing write protect turns protection off unless software enabled it.
// [RULE4] An enable sent before or during write protect keeps protection on after release.
// [RULE5] The disable command is ignored while write protect is asserted.
// [RULE6] Write protect passes a noise filter so glitches change nothing.
// [RULE7] The map holds four bytes, one per sector, sector zero first.
// [RULE8] Sector zero byte: bits 7,6 guard pages 0-7; bits 5,4 guard pages 8-127.
// [RULE9] Map erase sets every byte to all ones, so every sector is protected.
// [RULE10] Host writes only all zeros or all ones for sectors one to three.
// [RULE11] From reset the map reads all zeros, nothing protected.
// [RULE12] Host erases the map before programming it.
// [RULE13] Prefix then CFh and chip select high starts a timed busy map erase.
// [RULE14] Map erase is accepted with protection on or off.
// [RULE15] Host sends prefix, FCh, then four data bytes, sector zero first.
// [RULE16] Chip select high after the data starts a timed busy map program.
// [RULE17] Bytes not received before chip select rose leave their sector unchanged.
// [RULE18] Data bytes past the fourth wrap back to map byte zero.
// [RULE19] Map program is accepted with protection on or off.
// [RULE20] Map program data is also written into the SRAM buffer.
// [RULE21] Prefix then A9h and chip select high enables software protection.
// [RULE22] Prefix then 9Ah and chip select high disables it if write protect is off.
// [RULE23] Opcode 32h and three dummy bytes, then the map shifts out, sector zero first.
// [RULE24] Write protect filter is a two-flop synchroniser and a stable-level counter.
`timescale 1ns/1ns
`default_nettype none
`include "sect_prot_params.svh"

module sector_protect (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       arst_n,
   // Serial pins
   input  wire logic       cs_n,
   input  wire logic       sck,
   input  wire logic       si,
   input  wire logic       wp_n,
   output var  logic       so,
   output var  logic       so_oe,
   // Status
   output var  logic       busy,
   output var  logic       prot_on,
   output var  logic [4:0] sector_prot,
   // Main array erase or program check
   input  wire logic       arr_req,
   input  wire logic [2:0] arr_region,
   output var  logic       arr_grant,
   output var  logic       arr_refuse,
   // SRAM buffer write port
   output var  logic       buf_we,
   output var  logic [7:0] buf_addr,
   output var  logic [7:0] buf_wdata
);

   localparam int ERASE_LEN = `MAP_ERASE_CYC;
   localparam int PROG_LEN  = `MAP_PROGRAM_CYC;

   // ========================================================================
   // Helpers
   function automatic logic [7:0] map_byte(input logic [31:0] m, input logic [1:0] n);
      map_byte = m[{n, 3'b000} +: 8]; // [RULE7]
   endfunction

   // All-ones marks a sector; other values of sectors 1..3 count as unprotected
   function automatic logic [4:0] prot_decode(input logic [31:0] m);
      prot_decode[0] = m[`SUB0A_HI] & m[`SUB0A_LO]; // [RULE8]
      prot_decode[1] = m[`SUB0B_HI] & m[`SUB0B_LO]; // [RULE8]
      prot_decode[2] = &map_byte(m, 2'd1); // [RULE10]
      prot_decode[3] = &map_byte(m, 2'd2);
      prot_decode[4] = &map_byte(m, 2'd3);
   endfunction

   // ========================================================================
   // Pin synchronisers
   logic cs_s1, cs_s2, cs_q;
   logic sck_s1, sck_s2, sck_q;
   logic si_s1, si_s2;

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cs_s1  <= 1'b1;
         cs_s2  <= 1'b1;
         cs_q   <= 1'b1;
         sck_s1 <= 1'b0;
         sck_s2 <= 1'b0;
         sck_q  <= 1'b0;
         si_s1  <= 1'b0;
         si_s2  <= 1'b0;
      end
      else
      begin
         cs_s1  <= cs_n;
         cs_s2  <= cs_s1;
         cs_q   <= cs_s2;
         sck_s1 <= sck;
         sck_s2 <= sck_s1;
         sck_q  <= sck_s2;
         si_s1  <= si;
         si_s2  <= si_s1;
      end
   end

   // ========================================================================
   // Write protect filter
   wp_filter_if wpf ();
   logic        wp_on;

   assign wpf.wp_n_pin = wp_n;
   assign wp_on        = wpf.wp_on;

   wp_filter u_wp_filter (
      .mclk   (mclk),
      .arst_n (arst_n),
      .wp     (wpf)
   );

   // ========================================================================
   // Command, map and status state
   logic                  cs_act, cs_rise, cs_fall, sck_rise, sck_fall;
   logic [7:0]            byte_in;
   logic [4:0]            prot_ext_low;
   logic [7:0]            prot_ext;
   logic [2:0]            bit_cnt, next_bit_cnt;
   logic [2:0]            opc_cnt, next_opc_cnt;
   logic [7:0]            shift, next_shift;
   logic                  prefix_ok, next_prefix_ok;
   sect_prot_pkg::cmd_type cmd, next_cmd;
   sect_prot_pkg::op_type  op, next_op;
   logic [15:0]           timer, next_timer;
   logic [1:0]            data_idx, next_data_idx;
   logic [3:0]            seen, next_seen;
   logic [31:0]           stage, next_stage;
   logic [31:0]           map, next_map;
   logic [31:0]           out_sr, next_out_sr;
   logic                  read_on, next_read_on;
   logic                  sw_en, next_sw_en;
   logic                  next_so, next_so_oe, next_busy, next_prot_on;
   logic [4:0]            next_sector_prot;
   logic                  next_arr_grant, next_arr_refuse;
   logic                  next_buf_we;
   logic [7:0]            next_buf_addr, next_buf_wdata;

   assign cs_act       = ~cs_s2;
   assign cs_rise      = cs_s2 & ~cs_q;
   assign cs_fall      = ~cs_s2 & cs_q;
   assign sck_rise     = sck_s2 & ~sck_q;
   assign sck_fall     = ~sck_s2 & sck_q;
   assign byte_in      = {shift[6:0], si_s2};
   assign prot_ext_low = sector_prot;
   // Region codes above four have no sector behind them and are refused
   assign prot_ext     = {3'b111, prot_ext_low};

   always_comb
   begin
      next_bit_cnt     = bit_cnt;
      next_opc_cnt     = opc_cnt;
      next_shift       = shift;
      next_prefix_ok   = prefix_ok;
      next_cmd         = cmd;
      next_op          = op;
      next_timer       = timer;
      next_data_idx    = data_idx;
      next_seen        = seen;
      next_stage       = stage;
      next_map         = map;
      next_out_sr      = out_sr;
      next_read_on     = read_on;
      next_sw_en       = sw_en;
      next_so          = so;
      next_buf_we      = 1'b0;
      next_buf_addr    = buf_addr;
      next_buf_wdata   = buf_wdata;
      next_arr_grant   = 1'b0;
      next_arr_refuse  = 1'b0;

      // Serial receive, mode 0: data sampled on the rising serial clock
      if (!cs_act)
      begin
         next_bit_cnt   = 3'h0;
         next_opc_cnt   = 3'h0;
         next_prefix_ok = 1'b0;
         next_cmd       = sect_prot_pkg::cmd_none;
         next_read_on   = 1'b0;
      end
      else if (sck_rise)
      begin
         next_bit_cnt = bit_cnt + 3'h1;
         next_shift   = byte_in;
         if (bit_cnt == 3'h7)
         begin
            if (opc_cnt != `OPC_BYTES)
            begin
               next_opc_cnt = opc_cnt + 3'h1;
               unique case (opc_cnt)
                  3'h0:
                  begin
                     next_prefix_ok = (byte_in == `OPC_PREFIX0);
                     if (byte_in == `OPC_MAP_READ)
                        next_cmd = sect_prot_pkg::cmd_read;
                  end
                  3'h1: next_prefix_ok = prefix_ok && (byte_in == `OPC_PREFIX1);
                  3'h2: next_prefix_ok = prefix_ok && (byte_in == `OPC_PREFIX2);
                  3'h3:
                  begin
                     if (cmd == sect_prot_pkg::cmd_read)
                     begin
                        next_read_on = 1'b1; // [RULE23]
                        // Sector zero byte leaves first, so the shifter holds the map byte-reversed
                        next_out_sr  = {map[7:0], map[15:8], map[23:16], map[31:24]};
                     end
                     else if (prefix_ok && byte_in == `OPC_PROT_ENABLE)
                        next_cmd = sect_prot_pkg::cmd_enable;
                     else if (prefix_ok && byte_in == `OPC_PROT_DISABLE)
                        next_cmd = sect_prot_pkg::cmd_disable;
                     else if (prefix_ok && byte_in == `OPC_MAP_ERASE)
                        next_cmd = sect_prot_pkg::cmd_erase;
                     else if (prefix_ok && byte_in == `OPC_MAP_PROGRAM)
                        next_cmd = sect_prot_pkg::cmd_program;
                  end
                  default: next_opc_cnt = `OPC_BYTES;
               endcase
            end
            else if (cmd == sect_prot_pkg::cmd_program && op == sect_prot_pkg::op_idle)
            begin
               next_stage[{data_idx, 3'b000} +: 8] = byte_in;
               next_seen[data_idx]                 = 1'b1;
               next_data_idx                       = data_idx + 2'd1; // [RULE18]
               next_buf_we                         = 1'b1; // [RULE20]
               next_buf_addr                       = {6'h00, data_idx};
               next_buf_wdata                      = byte_in;
            end
         end
      end

      // Map read: each bit leaves on the falling edge, ready for the host's rising edge
      if (cs_act && sck_fall && read_on)
      begin
         next_so     = out_sr[31];
         next_out_sr = {out_sr[30:0], 1'b0};
      end
      next_so_oe = cs_act && next_read_on;

      // A new frame started while the map is idle forgets data bytes of an earlier one
      if (cs_fall && op == sect_prot_pkg::op_idle)
      begin
         next_seen     = 4'h0;
         next_data_idx = 2'd0;
      end

      // Chip select rising ends a whole command; commands that end while the map is busy are dropped
      if (cs_rise && opc_cnt == `OPC_BYTES && bit_cnt == 3'h0
          && op == sect_prot_pkg::op_idle)
      begin
         case (cmd)
            sect_prot_pkg::cmd_enable:
               next_sw_en = 1'b1; // [RULE21]
            sect_prot_pkg::cmd_disable:
               if (!wp_on)
                  next_sw_en = 1'b0; // [RULE22] [RULE5]
            sect_prot_pkg::cmd_erase:
               if (!wp_on) // [RULE1] [RULE14]
               begin
                  next_op    = sect_prot_pkg::op_erase; // [RULE13]
                  next_timer = 16'(ERASE_LEN - 1);
               end
            sect_prot_pkg::cmd_program:
               if (!wp_on) // [RULE1] [RULE19]
               begin
                  next_op    = sect_prot_pkg::op_program; // [RULE16]
                  next_timer = 16'(PROG_LEN - 1);
               end
            sect_prot_pkg::cmd_none,
            sect_prot_pkg::cmd_read: ;
            default: ;
         endcase
      end

      // Self-timed map cycle; the map changes only at its end
      if (op != sect_prot_pkg::op_idle)
      begin
         if (timer == 16'h0000)
         begin
            next_op = sect_prot_pkg::op_idle;
            if (op == sect_prot_pkg::op_erase)
               next_map = `MAP_ERASED; // [RULE9]
            else
               for (int i = 0; i < 4; i++)
                  if (seen[i])
                     next_map[i * 8 +: 8] = stage[i * 8 +: 8]; // [RULE17]
         end
         else
            next_timer = timer - 16'h0001;
      end

      next_busy        = (next_op != sect_prot_pkg::op_idle);
      // Pin forces protection on; a software enable outlives the pin
      next_prot_on     = next_sw_en | wp_on; // [RULE2] [RULE3] [RULE4]
      next_sector_prot = next_prot_on ? prot_decode(next_map) : 5'h00;

      if (arr_req)
      begin
         if (prot_ext[arr_region])
            next_arr_refuse = 1'b1; // [RULE1]
         else
            next_arr_grant = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bit_cnt     <= 3'h0;
         opc_cnt     <= 3'h0;
         shift       <= 8'h00;
         prefix_ok   <= 1'b0;
         cmd         <= sect_prot_pkg::cmd_none;
         op          <= sect_prot_pkg::op_idle;
         timer       <= 16'h0000;
         data_idx    <= 2'd0;
         seen        <= 4'h0;
         stage       <= 32'h0000_0000;
         map         <= `MAP_RESET; // [RULE11]
         out_sr      <= 32'h0000_0000;
         read_on     <= 1'b0;
         sw_en       <= 1'b0;
         so          <= 1'b0;
         so_oe       <= 1'b0;
         busy        <= 1'b0;
         prot_on     <= 1'b0;
         sector_prot <= 5'h00;
         arr_grant   <= 1'b0;
         arr_refuse  <= 1'b0;
         buf_we      <= 1'b0;
         buf_addr    <= 8'h00;
         buf_wdata   <= 8'h00;
      end
      else
      begin
         bit_cnt     <= next_bit_cnt;
         opc_cnt     <= next_opc_cnt;
         shift       <= next_shift;
         prefix_ok   <= next_prefix_ok;
         cmd         <= next_cmd;
         op          <= next_op;
         timer       <= next_timer;
         data_idx    <= next_data_idx;
         seen        <= next_seen;
         stage       <= next_stage;
         map         <= next_map;
         out_sr      <= next_out_sr;
         read_on     <= next_read_on;
         sw_en       <= next_sw_en;
         so          <= next_so;
         so_oe       <= next_so_oe;
         busy        <= next_busy;
         prot_on     <= next_prot_on;
         sector_prot <= next_sector_prot;
         arr_grant   <= next_arr_grant;
         arr_refuse  <= next_arr_refuse;
         buf_we      <= next_buf_we;
         buf_addr    <= next_buf_addr;
         buf_wdata   <= next_buf_wdata;
      end
   end

   // ========================================================================
   // Checks
   logic [15:0]           busy_len;
   sect_prot_pkg::op_type last_op;

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         busy_len <= 16'h0000;
         last_op  <= sect_prot_pkg::op_idle;
      end
      else
      begin
         busy_len <= busy ? busy_len + 16'h0001 : 16'h0000;
         if (op != sect_prot_pkg::op_idle)
            last_op <= op;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);

   AST_MAP_WP_LOCK: assert property ($rose(busy) |-> !$past(wp_on)) // [RULE1]
      else $error("map cycle started while write protect was asserted");

   AST_ARR_REFUSE: assert property (arr_req && prot_ext[arr_region] // [RULE1]
      |=> arr_refuse && !arr_grant)
      else $error("protected region was not refused");

   AST_WP_FORCES_ON: assert property (wp_on |=> prot_on) // [RULE2]
      else $error("protection off while write protect asserted");

   AST_RELEASE_OFF: assert property (!wp_on ##1 !sw_en // [RULE3]
      |-> !prot_on)
      else $error("protection stayed on after release without enable");

   AST_DIS_IGNORED: assert property (wp_on && sw_en |=> sw_en) // [RULE5]
      else $error("software enable dropped while write protect asserted");

   AST_ERASE_ONES: assert property (op == sect_prot_pkg::op_erase // [RULE9]
      && timer == 16'h0000 |=> map == `MAP_ERASED ##1 sector_prot == {5{prot_on}})
      else $error("map erase did not leave all ones");

   AST_BUSY_LEN: assert property ($fell(busy) |-> // [RULE16]
      busy_len == ((last_op == sect_prot_pkg::op_erase) ? 16'(ERASE_LEN) : 16'(PROG_LEN)))
      else $error("busy length differs from the map cycle time");

   AST_SUB0A: assert property (sector_prot[0] |-> // [RULE8]
      prot_on && map[`SUB0A_HI] && map[`SUB0A_LO])
      else $error("sub-sector guarded with protection off");

   AST_WRAP: assert property (buf_we && buf_addr == 8'h03 && cs_act // [RULE18]
      ##[1:64] buf_we |-> buf_addr == 8'h00)
      else $error("fifth data byte did not wrap to byte zero");

   AST_READ_LOAD: assert property ($rose(read_on) |-> // [RULE23]
      out_sr == {$past(map[7:0]), $past(map[15:8]), $past(map[23:16]), $past(map[31:24])})
      else $error("map read did not start from the stored map");

endmodule

`default_nettype wire

/* hw/wp_filter.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sect_prot_params.svh"

module wp_filter (
   // Clock and reset
   input wire logic   mclk,
   input wire logic   arst_n,
   // Pin in, filtered level out
   wp_filter_if.filt  wp
);

   localparam int FILT = `WP_FILTER_CYC;

   logic       sync1_n;
   logic       sync2_n;
   logic       level_n;
   logic       next_level_n;
   logic [7:0] cnt;
   logic [7:0] next_cnt;

   // ========================================================================
   // Synchroniser
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sync1_n <= 1'b1;
         sync2_n <= 1'b1;
      end
      else
      begin
         sync1_n <= wp.wp_n_pin;
         sync2_n <= sync1_n;
      end
   end

   // ========================================================================
   // Stability counter: a new level is taken only after FILT quiet cycles
   always_comb
   begin
      next_level_n = level_n;
      next_cnt     = cnt;
      if (sync2_n == level_n)
         next_cnt = 8'h00; // [RULE6]
      else if (cnt == 8'(FILT - 1))
      begin
         next_level_n = sync2_n; // [RULE24]
         next_cnt     = 8'h00;
      end
      else
         next_cnt = cnt + 8'h01;
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         level_n <= 1'b1;
         cnt     <= 8'h00;
      end
      else
      begin
         level_n <= next_level_n;
         cnt     <= next_cnt;
      end
   end

   assign wp.wp_on = ~level_n;

   // ========================================================================
   // Checks
   AST_WP_STABLE: assert property (@(posedge mclk) disable iff (!arst_n) // [RULE24]
      $changed(level_n) |-> $past(cnt) == 8'(FILT - 1))
      else $error("filtered write protect changed before the quiet time");

   AST_WP_GLITCH: assert property (@(posedge mclk) disable iff (!arst_n) // [RULE6]
      (sync2_n == level_n) |=> !$changed(level_n))
      else $error("filtered write protect followed a level it already had");

endmodule

`default_nettype wire

/* inc/sect_prot_params.svh */
`ifndef SECT_PROT_PARAMS_SVH
`define SECT_PROT_PARAMS_SVH

// ==========================================================================
// Clock
`define MCLK_MHZ            20

// ==========================================================================
// Timing: each time in its own unit, then the derived cycle count
`define WP_FILTER_NS        1000
`define WP_FILTER_CYC       ((`WP_FILTER_NS * `MCLK_MHZ + 999) / 1000)
`define MAP_ERASE_TIME_US   100
`define MAP_ERASE_CYC       (`MAP_ERASE_TIME_US * `MCLK_MHZ)
`define MAP_PROGRAM_TIME_US 50
`define MAP_PROGRAM_CYC     (`MAP_PROGRAM_TIME_US * `MCLK_MHZ)

// ==========================================================================
// Opcodes
`define OPC_PREFIX0         8'h3d
`define OPC_PREFIX1         8'h2a
`define OPC_PREFIX2         8'h7f
`define OPC_PROT_ENABLE     8'ha9
`define OPC_PROT_DISABLE    8'h9a
`define OPC_MAP_ERASE       8'hcf
`define OPC_MAP_PROGRAM     8'hfc
`define OPC_MAP_READ        8'h32
`define OPC_BYTES           3'h4

// ==========================================================================
// Map layout: byte n of the map sits at bits 8n+7..8n
`define MAP_RESET           32'h0000_0000
`define MAP_ERASED          32'hffff_ffff
`define SUB0A_HI            7
`define SUB0A_LO            6
`define SUB0B_HI            5
`define SUB0B_LO            4
`define REGION_COUNT        3'h5

`endif

/* inc/sect_prot_pkg.sv */
package sect_prot_pkg;

   typedef enum logic [2:0] {
      cmd_none,
      cmd_enable,
      cmd_disable,
      cmd_erase,
      cmd_program,
      cmd_read
   } cmd_type;

   typedef enum logic [1:0] {
      op_idle,
      op_erase,
      op_program
   } op_type;

endpackage

/* inc/wp_filter_if.sv */
`timescale 1ns/1ns
`default_nettype none

interface wp_filter_if;
   logic wp_n_pin;
   logic wp_on;

   modport filt (input wp_n_pin, output wp_on);
   modport user (output wp_n_pin, input wp_on);
endinterface

`default_nettype wire

/* tb/spi_host_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Host side of the serial link: mode 0, 400 ns link clock, idle low
module spi_host_model (
   // Clock
   input  wire logic mclk,
   // Serial pins
   output var  logic cs_n,
   output var  logic sck,
   output var  logic si,
   input  wire logic so
);
   initial
   begin
      cs_n = 1'b1;
      sck  = 1'b0;
      si   = 1'b0;
   end

   // Whole bytes, MSB first; so is sampled late in the high phase where it has settled
   task automatic xfer(input logic [71:0] d, input int n, output logic [31:0] rx);
      rx = '0;
      cs_n <= 1'b0;
      repeat (4) @(negedge mclk);
      for (int i = 0; i < n * 8; i++)
      begin
         si <= d[71 - i];
         repeat (4) @(negedge mclk);
         sck <= 1'b1;
         repeat (4) @(negedge mclk);
         rx = {rx[30:0], so};
         sck <= 1'b0;
      end
      repeat (4) @(negedge mclk);
      cs_n <= 1'b1;
      // A released line must not keep showing the last bit
      si <= ~si;
      repeat (8) @(negedge mclk);
   endtask
endmodule

`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sect_prot_params.svh"

module tb_top;
   logic        mclk, arst_n, cs_n, sck, si, wp_n, so, so_oe, busy, prot_on, en;
   logic        arr_req, arr_grant, arr_refuse, buf_we;
   logic [2:0]  arr_region;
   logic [4:0]  sector_prot;
   logic [7:0]  buf_addr, buf_wdata;
   logic [31:0] rx, map;
   logic [39:0] pdata;
   logic [15:0] buf_q[$];
   logic [1:0]  arr_q[$];
   int          num_errors, tests_run, blen, cycles;

   sector_protect u_sector_protect (
      .mclk(mclk), .arst_n(arst_n), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
      .so(so), .so_oe(so_oe), .busy(busy), .prot_on(prot_on), .sector_prot(sector_prot),
      .arr_req(arr_req), .arr_region(arr_region), .arr_grant(arr_grant),
      .arr_refuse(arr_refuse), .buf_we(buf_we), .buf_addr(buf_addr), .buf_wdata(buf_wdata));

   spi_host_model u_spi_host_model (.mclk(mclk), .cs_n(cs_n), .sck(sck), .si(si), .so(so));

   // ==========================================================================
   // Helpers
   function automatic logic [4:0] regions(input logic [31:0] m, input logic on);
      regions = {m[31:24] == 8'hff, m[23:16] == 8'hff, m[15:8] == 8'hff,
                 m[5:4] == 2'b11, m[7:6] == 2'b11} & {5{on}};
   endfunction

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic complete_run;
      if (num_errors == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic cmd(input logic [7:0] op);
      u_spi_host_model.xfer({24'h3d2a7f, op, 40'h0}, 4, rx);
   endtask

   task automatic read_map(input logic [31:0] exp);
      u_spi_host_model.xfer({8'h32, 64'h0}, 8, rx);
      chk("map", {exp[7:0], exp[15:8], exp[23:16], exp[31:24]}, rx);
      chk("so_oe", 0, so_oe);
   endtask

   task automatic timed(input int exp);
      for (int i = 0; i < 3000 && busy !== 1'b0; i++)
         @(negedge mclk);
      chk("busy cycles", exp, blen);
   endtask

   task automatic wait_prot(input logic e, input int lim);
      for (int i = 0; i < lim && prot_on !== e; i++)
         @(negedge mclk);
      chk("prot_on", {31'h0, e}, {31'h0, prot_on});
   endtask

   // Held high across back-to-back requests; the caller drops it
   task automatic arr(input logic [2:0] r);
      logic [4:0] pr;
      pr = regions(map, en);
      arr_req    <= 1'b1;
      arr_region <= r;
      arr_q.push_back((r > 3'h4 || pr[r]) ? 2'b01 : 2'b10);
      @(negedge mclk);
   endtask

   // ==========================================================================
   // Clock, monitor and hang guard
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   always @(negedge mclk)
   begin
      if (busy === 1'b1)
         blen++;
      if (buf_we === 1'b1)
         chk("buffer write", buf_q.pop_front(), {buf_addr, buf_wdata});
      if (arr_grant === 1'b1 || arr_refuse === 1'b1)
         chk("array answer", arr_q.pop_front(), {arr_grant, arr_refuse});
   end

   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         num_errors++;
         complete_run();
      end
   end

   // ==========================================================================
   // Main sequence
   initial
   begin
      arst_n     = 1'b0;
      wp_n       = 1'b1;
      arr_req    = 1'b0;
      arr_region = 3'h0;
      en         = 1'b0;
      map        = 32'h0;
      pdata      = 40'hc000ff0030;
      num_errors = 0;
      tests_run  = 0;
      blen       = 0;
      cycles     = 0;
      void'($urandom(32'hff89));
      repeat (2) @(negedge mclk);
      arst_n = 1'b1;
      repeat (4) @(negedge mclk);
      read_map(32'h0);
      for (int i = 0; i < 6; i++)
         arr(3'($urandom % 8));
      arr_req <= 1'b0;
      en = 1'b1;
      cmd(`OPC_PROT_ENABLE);
      chk("prot_on", 1, prot_on);
      blen = 0;
      cmd(`OPC_MAP_ERASE);
      timed(`MAP_ERASE_CYC);
      map = `MAP_ERASED;
      repeat (2) @(negedge mclk);
      chk("sector_prot", regions(map, en), sector_prot);
      read_map(map);
      for (int i = 0; i < 5; i++)
         buf_q.push_back({6'h0, i[1:0], pdata[39 - 8 * i -: 8]});
      blen = 0;
      u_spi_host_model.xfer({24'h3d2a7f, `OPC_MAP_PROGRAM, pdata}, 9, rx);
      timed(`MAP_PROGRAM_CYC);
      // Fifth byte 30 lands on byte zero; byte n sits at bits 8n+7..8n
      map = 32'h00ff0030;
      repeat (2) @(negedge mclk);
      chk("sector_prot", regions(map, en), sector_prot);
      read_map(map);
      for (int i = 0; i < 8; i++)
         arr(i[2:0]);
      arr_req <= 1'b0;
      wp_n <= 1'b0;
      repeat (30) @(negedge mclk);
      blen = 0;
      cmd(`OPC_MAP_ERASE);
      cmd(`OPC_PROT_DISABLE);
      chk("busy cycles", 0, blen);
      chk("prot_on", 1, prot_on);
      arr(3'h3);
      arr(3'h2);
      arr_req <= 1'b0;
      wp_n <= 1'b1;
      repeat (40) @(negedge mclk);
      chk("prot_on", 1, prot_on);
      en = 1'b0;
      cmd(`OPC_PROT_DISABLE);
      chk("prot_on", 0, prot_on);
      wp_n <= 1'b0;
      repeat (10) @(negedge mclk);
      wp_n <= 1'b1;
      repeat (40) @(negedge mclk);
      chk("prot_on", 0, prot_on);
      wp_n <= 1'b0;
      wait_prot(1'b1, 30);
      chk("sector_prot", regions(map, 1'b1), sector_prot);
      wp_n <= 1'b1;
      wait_prot(1'b0, 30);
      read_map(map);
      chk("pending", 0, buf_q.size() + arr_q.size());
      complete_run();
   end
endmodule

`default_nettype wire
